//--- core/fault_sup_pkg.sv
package fault_sup_pkg;

  // ==========================================
  // Transceiver modes, as selected by software
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_WAKE,
    MODE_NORMAL,
    MODE_RX_ONLY
  } can_mode_t;

  // ==========================================
  // Diagnostic flag positions
  localparam int DIAG_W        = 5;
  localparam int DIAG_TXRX     = 0;
  localparam int DIAG_OVERTEMP = 1;
  localparam int DIAG_RXD_CLMP = 2;
  localparam int DIAG_BUS      = 3;
  localparam int DIAG_SUPPLY   = 4;

  // ==========================================
  // Values after reset
  localparam logic [DIAG_W-1:0] DIAG_RST  = 5'h00;
  localparam logic              PIN_RST   = 1'h1;
  localparam logic              INHIB_RST = 1'h0;
  // Fault detectors idle low; a high reset level would fake every fault
  localparam logic              FAULT_RST = 1'h0;

  // ==========================================
  // Synchroniser depth (pin inputs)
  localparam int SYNC_STAGES = 3;

endpackage

//--- core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RST_LEVEL = fault_sup_pkg::PIN_RST
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output logic      o_level
);
  import fault_sup_pkg::*;

  logic [SYNC_STAGES-1:0] stage;
  logic [SYNC_STAGES-1:0] next_stage;
  logic                   next_level;

  // First stage feeds only the second; level moves once stages 2 and 3 agree
  always_comb begin
    next_stage = {stage[SYNC_STAGES-2:0], i_pin};
    next_level = (stage[1] == stage[2]) ? stage[2] : o_level;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage   <= {SYNC_STAGES{RST_LEVEL}};
      o_level <= RST_LEVEL;
    end else begin
      stage   <= next_stage;
      o_level <= next_level;
    end
  end

endmodule

//--- core/can_fault_supervisor.sv
// Overview of operation
// [R1] A transmit-to-receive pin short is detected and treated as transceiver failure.
// [R2] That short is latched into the diagnostic flags read over SPI.
// [R3] That short pulls the interrupt output low unless its enable is off.
// [R4] That short inhibits the transmitter until an SPI restore command arrives.
// [R5] Host should switch the transceiver supply off after a reported short.
// [R6] Overtemperature of the driver stage switches the transceiver off.
// [R7] After cooling, transceiver returns by itself, mode kept, no command needed.
// [R8] After cooling, transmit waits for a dominant-to-recessive edge on transmit input.
// [R9] Receive output stuck recessive during traffic is flagged; transmitter off meanwhile.
// [R10] After receive clamping, transmitter returns only on an SPI restore command.
// [R11] Bus line shorts set the bus fault flag and interrupt unless masked.
// [R12] A bus line short leaves the transceiver mode unchanged.
// [R13] Host detects high-to-low line short itself; no flag from the device.
// [R14] Split stabiliser on in normal and receive-only, released otherwise.
// [R15] Shared supply undervoltage monitor is used; host may switch transceiver off.
// [R16] Failure flags stay latched until software clears them over SPI.
`timescale 1ns/1ps
module can_fault_supervisor (
  input  wire logic                             i_clk,
  input  wire logic                             i_rst,
  input  wire logic                             i_txd,
  input  wire logic                             i_bus_rx,
  input  wire logic                             i_txrx_short,
  input  wire logic                             i_overtemp,
  input  wire logic                             i_rxd_clamp,
  input  wire logic                             i_bus_short,
  input  wire logic                             i_supply_uv,
  input  wire fault_sup_pkg::can_mode_t         i_mode,
  input  wire logic                             i_tx_restore,
  input  wire logic                             i_diag_clear,
  input  wire logic                             i_int_en_txrx,
  input  wire logic                             i_int_en_bus,
  output logic                                  o_tx_dominant,
  output logic                                  o_tx_enabled,
  output logic                                  o_xcvr_on,
  output logic                                  o_rxd,
  output logic                                  o_split_oe_n,
  output logic [fault_sup_pkg::DIAG_W-1:0]      o_diag,
  output logic                                  o_int_n
);
  import fault_sup_pkg::*;

  typedef enum logic [1:0] {
    OT_OK,
    OT_HOT,
    OT_WAIT_EDGE
  } ot_state_t;

  // ==========================================
  // Pin synchronisers
  logic txd_s;
  logic bus_rx_s;
  logic short_s;
  logic hot_s;
  logic clamp_s;
  logic bus_s;
  logic uv_s;

  pin_sync u_sync_txd   (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_txd),        .o_level(txd_s));
  pin_sync u_sync_rx    (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_bus_rx),     .o_level(bus_rx_s));
  // Fault pins reset to their idle level so release of reset reports nothing
  pin_sync #(.RST_LEVEL(FAULT_RST)) u_sync_short (.i_clk(i_clk), .i_rst(i_rst),
    .i_pin(i_txrx_short), .o_level(short_s));
  pin_sync #(.RST_LEVEL(FAULT_RST)) u_sync_hot (.i_clk(i_clk), .i_rst(i_rst),
    .i_pin(i_overtemp), .o_level(hot_s));
  pin_sync #(.RST_LEVEL(FAULT_RST)) u_sync_clamp (.i_clk(i_clk), .i_rst(i_rst),
    .i_pin(i_rxd_clamp), .o_level(clamp_s));
  pin_sync #(.RST_LEVEL(FAULT_RST)) u_sync_bus (.i_clk(i_clk), .i_rst(i_rst),
    .i_pin(i_bus_short), .o_level(bus_s));
  pin_sync #(.RST_LEVEL(FAULT_RST)) u_sync_uv (.i_clk(i_clk), .i_rst(i_rst),
    .i_pin(i_supply_uv), .o_level(uv_s));

  // ==========================================
  // Fault state
  ot_state_t          ot_state;
  ot_state_t          next_ot_state;
  logic               txd_prev;
  logic               txrx_inhib;
  logic               next_txrx_inhib;
  logic               clamp_inhib;
  logic               next_clamp_inhib;
  logic [DIAG_W-1:0]  diag_set;
  logic [DIAG_W-1:0]  next_diag;
  logic               txd_rise;
  logic               tx_ok;

  assign txd_rise = txd_s && !txd_prev;

  always_comb begin
    next_ot_state = ot_state;
    case (ot_state)
      OT_OK: begin
        if (hot_s) begin
          next_ot_state = OT_HOT;                  // see [R6]
        end
      end
      OT_HOT: begin
        if (!hot_s) begin
          next_ot_state = OT_WAIT_EDGE;            // see [R7]
        end
      end
      OT_WAIT_EDGE: begin
        if (hot_s) begin
          next_ot_state = OT_HOT;
        end else if (txd_rise) begin
          next_ot_state = OT_OK;                   // see [R8]
        end
      end
      default: begin
        next_ot_state = OT_OK;
      end
    endcase

    // Detection wins over a restore command in the same cycle
    next_txrx_inhib = txrx_inhib;
    if (short_s) begin
      next_txrx_inhib = 1'h1;                      // see [R1] see [R4]
    end else if (i_tx_restore) begin
      next_txrx_inhib = 1'h0;                      // see [R4]
    end

    next_clamp_inhib = clamp_inhib;
    if (clamp_s) begin
      next_clamp_inhib = 1'h1;                     // see [R9]
    end else if (i_tx_restore) begin
      next_clamp_inhib = 1'h0;                     // see [R10]
    end

    diag_set                = '0;
    diag_set[DIAG_TXRX]     = short_s;             // see [R2]
    diag_set[DIAG_OVERTEMP] = hot_s;
    diag_set[DIAG_RXD_CLMP] = clamp_s;
    diag_set[DIAG_BUS]      = bus_s;               // see [R11]
    diag_set[DIAG_SUPPLY]   = uv_s;                // see [R15]
    // Sticky: a fault present in the clear cycle stays set
    next_diag = (i_diag_clear ? '0 : o_diag) | diag_set; // see [R16]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ot_state    <= OT_OK;
      txd_prev    <= PIN_RST;
      txrx_inhib  <= INHIB_RST;
      clamp_inhib <= INHIB_RST;
      o_diag      <= DIAG_RST;
    end else begin
      ot_state    <= next_ot_state;
      txd_prev    <= txd_s;
      txrx_inhib  <= next_txrx_inhib;
      clamp_inhib <= next_clamp_inhib;
      o_diag      <= next_diag;
    end
  end

  // ==========================================
  // Outputs
  // Mode is only read, never altered by any fault
  logic next_tx_dom;
  logic next_tx_en;
  logic next_xcvr;
  logic next_rxd;
  logic next_split_oe_n;
  logic next_int_n;

  // Undervoltage only blocks the driver; switching off is left to the host
  assign tx_ok = (i_mode == MODE_NORMAL) && !txrx_inhib && !clamp_inhib
               && (ot_state == OT_OK) && !uv_s;    // see [R4] see [R8] see [R9] see [R15]

  always_comb begin
    next_xcvr       = (ot_state != OT_HOT) && (i_mode != MODE_OFF); // see [R6] see [R12]
    next_tx_en      = tx_ok;
    next_tx_dom     = tx_ok && !txd_s;
    next_rxd        = (next_xcvr && i_mode != MODE_WAKE) ? bus_rx_s : PIN_RST;
    next_split_oe_n = !((i_mode == MODE_NORMAL) || (i_mode == MODE_RX_ONLY)); // see [R14]
    next_int_n      = !((next_diag[DIAG_TXRX] && i_int_en_txrx)  // see [R3]
                      || (next_diag[DIAG_BUS] && i_int_en_bus)); // see [R11]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tx_dominant <= 1'h0;
      o_tx_enabled  <= 1'h0;
      o_xcvr_on     <= 1'h0;
      o_rxd         <= PIN_RST;
      o_split_oe_n  <= 1'h1;
      o_int_n       <= 1'h1;
    end else begin
      o_tx_dominant <= next_tx_dom;
      o_tx_enabled  <= next_tx_en;
      o_xcvr_on     <= next_xcvr;
      o_rxd         <= next_rxd;
      o_split_oe_n  <= next_split_oe_n;
      o_int_n       <= next_int_n;
    end
  end

  // ==========================================
  // Assertions
  property p_short_inhibits;
    @(posedge i_clk) disable iff (i_rst)
      short_s |=> txrx_inhib ##1 !o_tx_enabled;
  endproperty
  a_short_inhibits: assert property (p_short_inhibits) else $error("short did not inhibit"); // see [R4]

  property p_short_flag;
    @(posedge i_clk) disable iff (i_rst)
      short_s |=> o_diag[DIAG_TXRX];
  endproperty
  a_short_flag: assert property (p_short_flag) else $error("short flag not set"); // see [R2]

  property p_short_int;
    @(posedge i_clk) disable iff (i_rst)
      (short_s && i_int_en_txrx) |=> !o_int_n;
  endproperty
  a_short_int: assert property (p_short_int) else $error("short gave no interrupt"); // see [R3]

  property p_restore_only_cmd;
    @(posedge i_clk) disable iff (i_rst)
      (txrx_inhib && !i_tx_restore) |=> txrx_inhib;
  endproperty
  a_restore_only_cmd: assert property (p_restore_only_cmd) else $error("inhibit left"); // see [R4]

  property p_hot_off;
    @(posedge i_clk) disable iff (i_rst)
      hot_s |=> ##1 !o_xcvr_on;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("hot transceiver on"); // see [R6]

  property p_cool_wait_edge;
    @(posedge i_clk) disable iff (i_rst)
      (ot_state == OT_WAIT_EDGE && !txd_rise) |=> !o_tx_enabled;
  endproperty
  a_cool_wait_edge: assert property (p_cool_wait_edge) else $error("tx before edge"); // see [R8]

  property p_clamp_tx_off;
    @(posedge i_clk) disable iff (i_rst)
      clamp_s |=> ##1 !o_tx_dominant;
  endproperty
  a_clamp_tx_off: assert property (p_clamp_tx_off) else $error("clamp tx active"); // see [R9]

  property p_clamp_restore;
    @(posedge i_clk) disable iff (i_rst)
      (clamp_inhib && !clamp_s && !i_tx_restore) |=> clamp_inhib;
  endproperty
  a_clamp_restore: assert property (p_clamp_restore) else $error("clamp released"); // see [R10]

  property p_bus_flag;
    @(posedge i_clk) disable iff (i_rst)
      (bus_s && i_int_en_bus) |=> (o_diag[DIAG_BUS] && !o_int_n);
  endproperty
  a_bus_flag: assert property (p_bus_flag) else $error("bus fault not reported"); // see [R11]

  property p_split;
    @(posedge i_clk) disable iff (i_rst)
      (i_mode == MODE_WAKE || i_mode == MODE_OFF) |=> o_split_oe_n;
  endproperty
  a_split: assert property (p_split) else $error("split driven in low mode"); // see [R14]

  property p_sticky;
    @(posedge i_clk) disable iff (i_rst)
      (o_diag[DIAG_BUS] && !i_diag_clear) |=> o_diag[DIAG_BUS];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost"); // see [R16]

  c_short_restore: cover property (@(posedge i_clk) txrx_inhib ##1 !txrx_inhib);
  c_ot_cycle: cover property (@(posedge i_clk) ot_state == OT_WAIT_EDGE ##1 ot_state == OT_OK);
  c_bus_int: cover property (@(posedge i_clk) o_diag[DIAG_BUS] && !o_int_n);

endmodule

//--- tb/host_can_model.sv
`timescale 1ns/1ps
// ========================================
// Host controller on the transmit pin
module host_can_model (
  input  wire logic                        i_clk,
  input  wire logic                        i_bit,
  input  wire logic [fault_sup_pkg::DIAG_W-1:0] i_diag,
  output logic                             o_txd,
  output logic                             o_off_req
);
  import fault_sup_pkg::*;
  logic next_txd;
  always_comb begin
    next_txd = i_bit;
  end
  always_ff @(posedge i_clk) begin
    o_txd <= next_txd;
  end
  // Host cuts the supply on a short or undervoltage
  assign o_off_req = i_diag[DIAG_TXRX] | i_diag[DIAG_SUPPLY];
endmodule

//--- tb/tb_can_fault_supervisor.sv
`timescale 1ns/1ps
module tb_can_fault_supervisor;
  import fault_sup_pkg::*;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic tx_bit = 1'h1;
  logic bus_rx = 1'h1;
  logic txrx_sh = 1'h0;
  logic hot = 1'h0;
  logic clamp = 1'h0;
  logic bus_sh = 1'h0;
  logic uv = 1'h0;
  logic restore = 1'h0;
  logic clr = 1'h0;
  logic en_txrx = 1'h1;
  logic en_bus = 1'h1;
  can_mode_t mode = MODE_NORMAL;
  logic txd, tx_dom, tx_en, xcvr_on, rxd, split_n, int_n, off_req;
  logic [DIAG_W-1:0] diag;
  int n_mismatch = 0;
  int checks_done = 0;
  always #20 i_clk = ~i_clk;
  // Bus loops the driven level back to the receiver
  always @(posedge i_clk) bus_rx <= ~tx_dom;
  host_can_model i_host_can_model (.i_clk(i_clk), .i_bit(tx_bit), .i_diag(diag),
    .o_txd(txd), .o_off_req(off_req));
  can_fault_supervisor i_can_fault_supervisor (.i_clk(i_clk), .i_rst(i_rst),
    .i_txd(txd), .i_bus_rx(bus_rx), .i_txrx_short(txrx_sh), .i_overtemp(hot),
    .i_rxd_clamp(clamp), .i_bus_short(bus_sh), .i_supply_uv(uv), .i_mode(mode),
    .i_tx_restore(restore), .i_diag_clear(clr), .i_int_en_txrx(en_txrx),
    .i_int_en_bus(en_bus), .o_tx_dominant(tx_dom), .o_tx_enabled(tx_en),
    .o_xcvr_on(xcvr_on), .o_rxd(rxd), .o_split_oe_n(split_n), .o_diag(diag),
    .o_int_n(int_n));
  // ========================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chkd(input logic [DIAG_W-1:0] exp);
    checks_done++;
    if (diag !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t diag got %h exp %h", $time, diag, exp);
    end
  endtask
  task automatic pulse(input bit is_clear);
    @(posedge i_clk);
    if (is_clear) clr <= 1'h1;
    else restore <= 1'h1;
    @(posedge i_clk);
    clr <= 1'h0;
    restore <= 1'h0;
    step(2);
  endtask
  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ========================================
  // Scenarios
  task automatic t_split;
    for (int m = 0; m < 5; m++) begin
      @(posedge i_clk);
      mode <= can_mode_t'(m % 4);
      step(3);
      chk1(split_n, !(m % 4 == 2 || m % 4 == 3), "split");
    end
    @(posedge i_clk);
    mode <= MODE_NORMAL;
    step(3);
  endtask
  task automatic t_txrx(input logic en);
    @(posedge i_clk);
    en_txrx <= en;
    txrx_sh <= 1'h1;
    step(6);
    chkd(5'h01);
    chk1(int_n, !en, "int");
    chk1(tx_en, 1'h0, "inhibit");
    pulse(1'b0);
    chk1(tx_en, 1'h0, "early restore");
    chk1(off_req, 1'h1, "off req");
    @(posedge i_clk);
    mode <= MODE_OFF;
    txrx_sh <= 1'h0;
    step(6);
    chk1(xcvr_on, 1'h0, "off");
    chkd(5'h01);
    @(posedge i_clk);
    mode <= MODE_NORMAL;
    step(3);
    chk1(tx_en, 1'h0, "no auto");
    pulse(1'b0);
    chk1(tx_en, 1'h1, "restore");
    pulse(1'b1);
    chkd(5'h00);
    chk1(int_n, 1'h1, "int clr");
  endtask
  task automatic t_hot;
    @(posedge i_clk);
    hot <= 1'h1;
    step(6);
    chk1(xcvr_on, 1'h0, "hot");
    @(posedge i_clk);
    tx_bit <= 1'h0;
    step(7);
    @(posedge i_clk);
    hot <= 1'h0;
    step(7);
    chk1(xcvr_on, 1'h1, "cool");
    chk1(tx_en, 1'h0, "wait edge");
    chk1(tx_dom, 1'h0, "no drive");
    @(posedge i_clk);
    tx_bit <= 1'h1;
    step(7);
    chk1(tx_en, 1'h1, "released");
    @(posedge i_clk);
    tx_bit <= 1'h0;
    step(7);
    chk1(tx_dom, 1'h1, "drive");
    step(6);
    chk1(rxd, 1'h0, "echo");
    @(posedge i_clk);
    tx_bit <= 1'h1;
    step(6);
    chkd(5'h02);
    pulse(1'b1);
    chkd(5'h00);
  endtask
  task automatic t_clamp;
    @(posedge i_clk);
    clamp <= 1'h1;
    step(6);
    chkd(5'h04);
    chk1(tx_en, 1'h0, "clamp");
    @(posedge i_clk);
    clamp <= 1'h0;
    step(6);
    chk1(tx_en, 1'h0, "stay off");
    pulse(1'b0);
    chk1(tx_en, 1'h1, "restore");
    pulse(1'b1);
  endtask
  task automatic t_bus(input logic en);
    @(posedge i_clk);
    en_bus <= en;
    bus_sh <= 1'h1;
    step(6);
    chkd(5'h08);
    chk1(int_n, !en, "bus int");
    chk1(tx_en, 1'h1, "mode kept");
    @(posedge i_clk);
    bus_sh <= 1'h0;
    step(6);
    pulse(1'b1);
    chkd(5'h00);
  endtask
  task automatic t_uv;
    @(posedge i_clk);
    uv <= 1'h1;
    step(6);
    chk1(tx_en, 1'h0, "uv");
    chkd(5'h10);
    @(posedge i_clk);
    uv <= 1'h0;
    step(6);
    chk1(tx_en, 1'h1, "uv gone");
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'h0;
    step(6);
    chkd(5'h00);
    t_split;
    t_txrx(1'h1);
    t_txrx(1'h0);
    t_hot;
    t_clamp;
    t_bus(1'h1);
    t_bus(1'h0);
    t_uv;
    conclude;
  end
  // Whole run needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    conclude;
  end
endmodule
